// ---- pcsia_cfg.svh ----
// Constants of the program-flow and indirect-addressing block
`ifndef PCSIA_CFG_SVH
`define PCSIA_CFG_SVH
`define PCSIA_OFS_PC_LOW  12'h000
`define PCSIA_OFS_LATCH   12'h004
`define PCSIA_OFS_POINTER 12'h008
`define PCSIA_OFS_STATUS  12'h00c
`define PCSIA_BANK_POS    7
`define PCSIA_IRQ_VECTOR  13'h0004
`define PCSIA_PC_RST      13'h0000
`define PCSIA_LATCH_RST   5'h00
`define PCSIA_POINTER_RST 8'h00
`define PCSIA_STK_DEPTH   8
`define PCSIA_PORT_LOW    7'h00
`define PCSIA_NULL_DATA   8'h00
`endif

// ---- pcsia_pkg.sv ----
// Types of the program-flow and indirect-addressing block
package pcsia_pkg;
	typedef enum logic [2:0] {
		PCSIA_OP_NONE  = 3'b000,
		PCSIA_OP_STEP  = 3'b001,
		PCSIA_OP_JUMP  = 3'b010,
		PCSIA_OP_CALL  = 3'b011,
		PCSIA_OP_RET   = 3'b100,
		PCSIA_OP_IRQ   = 3'b101,
		PCSIA_OP_PCLWR = 3'b110
	} pcsia_op_t;
	typedef enum logic [2:0] {
		PCSIA_SEL_PC_LOW  = 3'b000,
		PCSIA_SEL_LATCH   = 3'b001,
		PCSIA_SEL_POINTER = 3'b010,
		PCSIA_SEL_STATUS = 3'b011,
		PCSIA_SEL_NONE   = 3'b111
	} pcsia_sel_t;
endpackage

// ---- pcsia_core.sv ----
// Program counter, return stack and indirect data access with APB registers
`timescale 1ns/10ps
`include "pcsia_cfg.svh"
module pcsia_core import pcsia_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Execution core flow requests
	input  wire pcsia_op_t   op,
	input  wire logic [10:0] op_target,
	input  wire logic [7:0]  op_data,
	output logic      [12:0] pc,
	// Execution core data access
	input  wire logic        dacc_valid,
	input  wire logic [8:0]  dacc_addr,
	input  wire logic        dacc_we,
	input  wire logic [7:0]  dacc_wdata,
	output logic             dacc_rvalid,
	output logic      [7:0]  dacc_rdata,
	// Data memory
	output logic             mem_valid,
	output logic      [8:0]  mem_addr,
	output logic             mem_we,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	function automatic pcsia_sel_t reg_sel(input logic [11:0] a);
		case (a)
			`PCSIA_OFS_PC_LOW:  reg_sel = PCSIA_SEL_PC_LOW;
			`PCSIA_OFS_LATCH:   reg_sel = PCSIA_SEL_LATCH;
			`PCSIA_OFS_POINTER: reg_sel = PCSIA_SEL_POINTER;
			`PCSIA_OFS_STATUS: reg_sel = PCSIA_SEL_STATUS;
			default:           reg_sel = PCSIA_SEL_NONE;
		endcase
	endfunction

	// ********************************
	// APB slave and software registers
	// ********************************
	logic [4:0]  pc_high_latch;
	logic [7:0]  file_pointer;
	logic        bank;
	logic [4:0]  next_pc_high_latch;
	logic [7:0]  next_file_pointer;
	logic        next_bank;
	logic        next_pready;
	logic        next_pslverr;
	logic [31:0] next_prdata;
	logic        apb_wr;
	logic        apb_pcl_wr;
	pcsia_sel_t  rd_sel;
	pcsia_sel_t  wr_sel;

	// Write lands on the edge where the master sees pready
	assign apb_wr     = psel && penable && pready && pwrite;
	assign wr_sel     = reg_sel(paddr);
	assign apb_pcl_wr = apb_wr && (wr_sel == PCSIA_SEL_PC_LOW);

	always_comb begin
		rd_sel       = reg_sel(paddr);
		next_pready  = psel && penable && !pready;
		next_pslverr = next_pready && (rd_sel == PCSIA_SEL_NONE);
		next_prdata  = prdata;
		next_pc_high_latch = pc_high_latch;
		next_file_pointer  = file_pointer;
		next_bank    = bank;
		// Read data is formed one cycle ahead, while the access phase waits
		if (next_pready && !pwrite) begin
			case (rd_sel)
				PCSIA_SEL_PC_LOW:  next_prdata = {24'h000000, pc[7:0]};
				PCSIA_SEL_LATCH:   next_prdata = {27'h0000000, pc_high_latch};
				PCSIA_SEL_POINTER: next_prdata = {24'h000000, file_pointer};
				PCSIA_SEL_STATUS: next_prdata = {24'h000000, bank, 7'h00};
				default:          next_prdata = 32'h00000000;
			endcase
		end
		if (apb_wr) begin
			case (wr_sel)
				PCSIA_SEL_LATCH:   next_pc_high_latch = pwdata[4:0];
				PCSIA_SEL_POINTER: next_file_pointer = pwdata[7:0];
				PCSIA_SEL_STATUS:  next_bank = pwdata[`PCSIA_BANK_POS];
				default:           next_pc_high_latch = pc_high_latch;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			pc_high_latch <= `PCSIA_LATCH_RST;
			file_pointer  <= `PCSIA_POINTER_RST;
			bank    <= 1'b0;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
			pc_high_latch <= next_pc_high_latch;
			file_pointer  <= next_file_pointer;
			bank    <= next_bank;
		end
	end

	// ********************************
	// Program counter and return stack
	// ********************************
	logic [12:0] stk [`PCSIA_STK_DEPTH];
	logic [2:0]  sp;
	logic [12:0] next_pc;
	logic [2:0]  next_sp;
	logic        push;
	logic        pop;
	logic [12:0] push_val;
	logic [2:0]  top_idx;

	// A low byte register write outranks the core in the same cycle
	assign push    = !apb_pcl_wr && (op == PCSIA_OP_CALL || op == PCSIA_OP_IRQ);
	assign pop     = !apb_pcl_wr && (op == PCSIA_OP_RET);
	assign top_idx = sp - 3'd1;

	always_comb begin
		next_pc  = pc;
		next_sp  = sp;
		// Interrupt preempts the current address, call resumes after itself
		push_val = (op == PCSIA_OP_IRQ) ? pc : pc + 13'h0001;
		if (apb_pcl_wr) begin
			next_pc = {pc_high_latch, pwdata[7:0]};
		end else begin
			case (op)
				PCSIA_OP_STEP:  next_pc = pc + 13'h0001;
				PCSIA_OP_JUMP:  next_pc = {pc_high_latch[4:3], op_target};
				PCSIA_OP_CALL:  next_pc = {pc_high_latch[4:3], op_target};
				PCSIA_OP_IRQ:   next_pc = `PCSIA_IRQ_VECTOR;
				PCSIA_OP_RET:   next_pc = stk[top_idx];
				// No carry into the high part: the latch always supplies it
				PCSIA_OP_PCLWR: next_pc = {pc_high_latch, op_data};
				default:        next_pc = pc;
			endcase
		end
		// Pointer wraps in three bits, silently in both directions
		if (push) begin
			next_sp = sp + 3'd1;
		end else if (pop) begin
			next_sp = top_idx;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc <= `PCSIA_PC_RST;
			sp <= 3'd0;
		end else begin
			pc <= next_pc;
			sp <= next_sp;
		end
	end

	// Entries need no reset; stale ones are only seen after underflow
	always_ff @(posedge clk) begin
		if (push) begin
			stk[sp] <= push_val;
		end
	end

	// ********************************
	// Indirect data access
	// ********************************
	logic       via_port;
	logic [8:0] eff_addr;
	logic       null_sel;
	logic       next_mem_valid;
	logic [8:0] next_mem_addr;
	logic       next_mem_we;
	logic [7:0] next_mem_wdata;
	logic       rd_pend;
	logic       null_pend;
	logic       next_rd_pend;
	logic       next_null_pend;
	logic       next_rvalid;
	logic [7:0] next_rdata;

	always_comb begin
		// Port sits at the same low address in every bank
		via_port       = dacc_addr[6:0] == `PCSIA_PORT_LOW;
		eff_addr       = via_port ? {bank, file_pointer} : dacc_addr;
		null_sel       = via_port && (eff_addr[6:0] == `PCSIA_PORT_LOW);
		next_mem_valid = dacc_valid && !null_sel;
		next_mem_addr  = dacc_valid ? eff_addr : mem_addr;
		next_mem_we    = dacc_valid && dacc_we && !null_sel;
		next_mem_wdata = dacc_valid ? dacc_wdata : mem_wdata;
		next_rd_pend   = dacc_valid && !dacc_we;
		next_null_pend = dacc_valid && !dacc_we && null_sel;
		next_rvalid    = rd_pend;
		next_rdata     = dacc_rdata;
		if (rd_pend) begin
			next_rdata = null_pend ? `PCSIA_NULL_DATA : mem_rdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem_valid   <= 1'b0;
			mem_addr    <= 9'h000;
			mem_we      <= 1'b0;
			mem_wdata   <= 8'h00;
			rd_pend     <= 1'b0;
			null_pend   <= 1'b0;
			dacc_rvalid <= 1'b0;
			dacc_rdata  <= 8'h00;
		end else begin
			mem_valid   <= next_mem_valid;
			mem_addr    <= next_mem_addr;
			mem_we      <= next_mem_we;
			mem_wdata   <= next_mem_wdata;
			rd_pend     <= next_rd_pend;
			null_pend   <= next_null_pend;
			dacc_rvalid <= next_rvalid;
			dacc_rdata  <= next_rdata;
		end
	end

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_call;
		op == PCSIA_OP_CALL && !apb_pcl_wr;
	endsequence

	sequence s_ret;
		op == PCSIA_OP_RET && !apb_pcl_wr;
	endsequence

	sequence s_null_rd;
		dacc_valid && !dacc_we && via_port && ({bank, file_pointer} & 9'h07f) == 9'h000;
	endsequence

	sequence s_irq;
		op == PCSIA_OP_IRQ && !apb_pcl_wr;
	endsequence

	sequence s_pc_write;
		apb_pcl_wr;
	endsequence

	chk_call_push_val: assert property (s_call |=> stk[top_idx] == $past(pc) + 13'h0001)
		else $error("call pushed wrong return address");

	chk_call_ret_pair: assert property (s_call ##1 s_ret |=> pc == $past(pc, 2) + 13'h0001)
		else $error("return did not resume after call");

	chk_jump_page: assert property (op == PCSIA_OP_JUMP && !apb_pcl_wr
		|=> pc == {$past(pc_high_latch[4:3]), $past(op_target)})
		else $error("jump target not formed from page bits");

	chk_pcl_load: assert property (op == PCSIA_OP_PCLWR && !apb_pcl_wr
		|=> pc == {$past(pc_high_latch), $past(op_data)})
		else $error("low byte write did not load latch bits");

	chk_latch_keep: assert property ((push || pop) && !apb_wr |=> $stable(pc_high_latch))
		else $error("stack action changed the latch");

	chk_stack_wrap: assert property (push |=> sp == $past(sp) + 3'd1)
		else $error("stack pointer did not advance circularly");

	chk_null_read: assert property (s_null_rd |-> ##2 dacc_rvalid && dacc_rdata == 8'h00)
		else $error("self-pointing read did not return zero");

	chk_null_write: assert property (dacc_valid && dacc_we && null_sel |=> !mem_valid && !mem_we)
		else $error("self-pointing write reached memory");

	chk_ind_addr: assert property (dacc_valid && via_port && !null_sel
		|=> mem_valid && mem_addr == {$past(bank), $past(file_pointer)})
		else $error("indirect address not bank over pointer");

	chk_upper_hidden: assert property (pready && !pwrite && $past(rd_sel) == PCSIA_SEL_PC_LOW
		|-> prdata[31:8] == 24'h000000)
		else $error("upper counter bits became readable");

	// Interrupt vectoring: push the interrupted address and enter the vector on the same edge
	chk_irq_vector: assert property (s_irq
		|=> pc == `PCSIA_IRQ_VECTOR)
		else $error("interrupt did not enter the vector");

	chk_irq_push_val: assert property (s_irq
		|=> stk[top_idx] == $past(pc))
		else $error("interrupt pushed wrong resume address");

	chk_irq_sp_step: assert property (s_irq
		|=> sp == $past(sp) + 3'd1)
		else $error("interrupt did not push");

	chk_call_page: assert property (s_call
		|=> pc == {$past(pc_high_latch[4:3]), $past(op_target)})
		else $error("call target not formed from page bits");

	// Returns take the whole entry, the latch plays no part
	chk_ret_restore: assert property (s_ret
		|=> pc == $past(stk[top_idx]))
		else $error("return did not restore the stack entry");

	chk_ret_pop: assert property (s_ret
		|=> sp == $past(sp) - 3'd1)
		else $error("return did not pop");

	chk_step_incr: assert property (op == PCSIA_OP_STEP && !apb_pcl_wr
		|=> pc == $past(pc) + 13'h0001)
		else $error("step did not advance the counter");

	chk_jump_no_stack: assert property (op == PCSIA_OP_JUMP && !apb_pcl_wr
		|=> sp == $past(sp))
		else $error("jump moved the stack pointer");

	chk_apb_pc_load: assert property (s_pc_write
		|=> pc == {$past(pc_high_latch), $past(pwdata[7:0])})
		else $error("register write of low byte did not load latch bits");

	chk_apb_pc_wins: assert property (s_pc_write
		|=> sp == $past(sp))
		else $error("core op acted beside a low byte write");

	chk_latch_write: assert property (apb_wr && wr_sel == PCSIA_SEL_LATCH
		|=> pc_high_latch == $past(pwdata[4:0]))
		else $error("latch write did not land");

	chk_pointer_write: assert property (apb_wr && wr_sel == PCSIA_SEL_POINTER
		|=> file_pointer == $past(pwdata[7:0]))
		else $error("pointer write did not land");

	chk_bank_write: assert property (apb_wr && wr_sel == PCSIA_SEL_STATUS
		|=> bank == $past(pwdata[`PCSIA_BANK_POS]))
		else $error("bank bit write did not land");

	// One wait state, and an unmapped offset is refused with an error
	chk_err_unmapped: assert property (psel && penable && !pready && reg_sel(paddr) == PCSIA_SEL_NONE
		|=> pready && pslverr)
		else $error("unmapped offset not refused");

	chk_pc_low_read: assert property (psel && penable && !pready && !pwrite && rd_sel == PCSIA_SEL_PC_LOW
		|=> prdata == {24'h000000, $past(pc[7:0])})
		else $error("low byte read returned wrong value");

	chk_direct_pass: assert property (dacc_valid && !via_port
		|=> mem_valid && mem_addr == $past(dacc_addr))
		else $error("direct access not passed to memory");

	chk_write_data: assert property (dacc_valid && dacc_we && !null_sel
		|=> mem_we && mem_wdata == $past(dacc_wdata))
		else $error("write data not passed to memory");

	chk_read_return: assert property (dacc_valid && !dacc_we && !null_sel
		|-> ##2 dacc_rvalid && dacc_rdata == $past(mem_rdata))
		else $error("read data not returned from memory");

	chk_null_no_mem: assert property (s_null_rd
		|=> !mem_valid)
		else $error("self-pointing read reached memory");

endmodule

// ---- pcsia_dmem.sv ----
// Data memory model on the far side of the block
`timescale 1ns/10ps
module pcsia_dmem (
	// Clock
	input  wire logic       clk,
	// Memory access
	input  wire logic       mem_valid,
	input  wire logic [8:0] mem_addr,
	input  wire logic       mem_we,
	input  wire logic [7:0] mem_wdata,
	output logic      [7:0] mem_rdata
);
	logic [7:0] ram [512];
	logic [7:0] junk = 8'h5a;
	// Outside a read cycle the bus churns, so stale data never looks valid
	assign mem_rdata = (mem_valid && !mem_we) ? ram[mem_addr] : junk;
	always @(posedge clk) begin
		junk <= junk + 8'h3b;
		if (mem_valid && mem_we) begin
			ram[mem_addr] <= mem_wdata;
		end
	end
endmodule

// ---- tb_top.sv ----
// Self-checking testbench of the program-flow and indirect-addressing block
`timescale 1ns/10ps
`include "pcsia_cfg.svh"
module tb_top import pcsia_pkg::*; ;
	logic        clk = 1'b0, nrst = 1'b0, dacc_valid = 1'b0, dacc_we = 1'b0, dacc_rvalid, mem_valid, mem_we;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [7:0]  op_data = 8'h00, dacc_wdata = 8'h00, dacc_rdata, mem_wdata, mem_rdata;
	logic [8:0]  dacc_addr = 9'h000, mem_addr;
	logic [10:0] op_target = 11'h000;
	logic [11:0] paddr = 12'h000;
	logic [12:0] pc, epc;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [12:0] stk [8];
	logic [2:0]  sp;
	pcsia_op_t   op = PCSIA_OP_NONE;
	int          fails = 0, check_count = 0;

	pcsia_core i_dut (.clk, .nrst, .op, .op_target, .op_data, .pc, .dacc_valid, .dacc_addr, .dacc_we, .dacc_wdata,
		.dacc_rvalid, .dacc_rdata, .mem_valid, .mem_addr, .mem_we, .mem_wdata, .mem_rdata,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	pcsia_dmem i_mem (.clk, .mem_valid, .mem_addr, .mem_we, .mem_wdata, .mem_rdata);

	// ************************
	// Shared tasks
	// ************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Leaves the op driven after its edge; the caller ends each run with a NONE step
	task automatic step(input pcsia_op_t o, input logic [10:0] t, input logic [12:0] e);
		op        <= o;
		op_target <= t;
		@(posedge clk);
		fork
			begin
				@(negedge clk);
				cmp(32'(pc), 32'(e));
			end
		join_none
	endtask

	// A null target is given as memory address zero: no memory cycle expected
	task automatic dat(input logic w, input logic [8:0] a, input logic [7:0] d, input logic [8:0] ma,
		input logic [7:0] er);
		dacc_valid <= 1'b1;
		dacc_we    <= w;
		dacc_addr  <= a;
		dacc_wdata <= d;
		@(posedge clk);
		dacc_valid <= 1'b0;
		@(negedge clk);
		cmp(32'(mem_valid), 32'(ma != 9'h000));
		if (ma != 9'h000) begin
			cmp(32'(mem_addr), 32'(ma));
		end
		@(negedge clk);
		if (!w) begin
			cmp(32'(dacc_rvalid), 32'h1);
			cmp(32'(dacc_rdata), 32'(er));
		end
		@(posedge clk);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic t_pcwrite();
		cmp(32'(pc), 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b1, 12'h004, 32'h1f);
		apb(1'b1, 12'h000, 32'h34);
		cmp(32'(pc), 32'h1f34);
		apb(1'b0, 12'h000, 32'h0);
		cmp(rd, 32'h34);
		apb(1'b0, 12'h010, 32'h0);
		cmp(32'(err), 32'h1);
	endtask

	task automatic t_jump();
		op_data <= 8'h7e;
		step(PCSIA_OP_JUMP, 11'h123, 13'h1923);
		step(PCSIA_OP_STEP, 11'h0, 13'h1924);
		step(PCSIA_OP_PCLWR, 11'h0, 13'h1f7e);
		op_data <= 8'h02;
		step(PCSIA_OP_PCLWR, 11'h0, 13'h1f02);
		op_data <= 8'h7e;
		step(PCSIA_OP_PCLWR, 11'h0, 13'h1f7e);
		epc = 13'h1f7e;
		step(PCSIA_OP_NONE, 11'h0, epc);
	endtask

	task automatic t_stack();
		apb(1'b1, 12'h004, 32'h0);
		for (int i = 0; i < 9; i++) begin
			stk[i % 8] = epc + 13'h1;
			epc = 13'(i * 16 + 8);
			step(PCSIA_OP_CALL, 11'(i * 16 + 8), epc);
		end
		step(PCSIA_OP_NONE, 11'h0, epc);
		apb(1'b1, 12'h004, 32'h18);
		sp = 3'd1;
		for (int j = 0; j < 9; j++) begin
			sp = sp - 3'd1;
			epc = stk[sp];
			step(PCSIA_OP_RET, 11'h0, epc);
		end
		step(PCSIA_OP_NONE, 11'h0, epc);
		apb(1'b0, 12'h004, 32'h0);
		cmp(rd, 32'h18);
		apb(1'b0, 12'h00c, 32'h0);
		cmp(rd, 32'h0);
	endtask

	task automatic t_irq();
		step(PCSIA_OP_IRQ, 11'h0, `PCSIA_IRQ_VECTOR);
		step(PCSIA_OP_STEP, 11'h0, `PCSIA_IRQ_VECTOR + 13'h1);
		step(PCSIA_OP_RET, 11'h0, epc);
		step(PCSIA_OP_NONE, 11'h0, epc);
	endtask

	task automatic t_indirect();
		apb(1'b1, 12'h008, 32'h25);
		apb(1'b1, 12'h00c, 32'h80);
		dat(1'b1, 9'h000, 8'ha5, 9'h125, 8'h00);
		dat(1'b0, 9'h000, 8'h00, 9'h125, 8'ha5);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h00c, 32'h0);
		dat(1'b0, 9'h000, 8'h00, 9'h000, 8'h00);
		dat(1'b1, 9'h000, 8'h5c, 9'h000, 8'h00);
		dat(1'b0, 9'h125, 8'h00, 9'h125, 8'ha5);
	endtask

	// ************************
	// Clock, watchdog and sequence
	// ************************
	initial begin
		forever #2 clk = ~clk;
	end

	initial begin
		#20000;
		fails++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_pcwrite();
		t_jump();
		t_stack();
		t_irq();
		t_indirect();
		complete_run();
	end
endmodule
